//--- logic/axis_interrupt_status_bank.sv
// Top: per-axis sticky interrupt condition bank with host access
`timescale 1ns/1ns
module axis_interrupt_status_bank
   import axis_irq_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [NUM_AXES-1:0] following_error_halt_event,
   input wire logic [NUM_AXES-1:0] following_error_event,
   input wire logic [NUM_AXES-1:0] index_pulse_event,
   input wire logic [NUM_AXES-1:0] position_breakpoint_event,
   input wire logic [NUM_AXES-1:0] motion_complete_event,
   input wire logic [NUM_AXES-1:0] probe_event,
   input wire logic [NUM_AXES-1:0] conflict_event,
   input wire logic [NUM_AXES-1:0] ignored_cmd_event,
   input wire logic [NUM_AXES-1:0] encoder_fault_event,
   input wire logic [NUM_AXES-1:0] offset_done_event,
   input wire logic [NUM_AXES-1:0] user_host_event,
   input wire logic [NUM_AXES-1:0] user_error_event,
   input wire logic condition_clear_request,
   input wire logic condition_test_request,
   input wire logic [AXIS_W-1:0] req_axis,
   input wire logic [COND_W-1:0] req_mask,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   output logic test_valid,
   output logic test_result,
   output logic periodic_tick_event,
   output logic irq
);
   // ==========================================================
   // Event gathering
   logic [NUM_AXES*COND_W-1:0] set_vec;
   logic [NUM_AXES*COND_W-1:0] all_words;
   logic tick_en_q;
   logic [TICK_CNT_W-1:0] tick_cnt_q;
   logic tick_pulse;

   genvar a;
   generate
      for (a = 0; a < NUM_AXES; a++) begin : g_set
         logic [COND_W-1:0] s;
         always_comb begin
            s = '0;
            s[BIT_ERR_HALT] = following_error_halt_event[a];
            s[BIT_ERR] = following_error_event[a];
            s[BIT_INDEX] = index_pulse_event[a];
            s[BIT_POS_BRK] = position_breakpoint_event[a];
            s[BIT_MOT_DONE] = motion_complete_event[a];
            s[BIT_PROBE] = probe_event[a];
            s[BIT_CONFLICT] = conflict_event[a];
            s[BIT_IGNORED] = ignored_cmd_event[a];
            s[BIT_ENC_FAULT] = encoder_fault_event[a];
            s[BIT_OFFSET_DONE] = offset_done_event[a];
            s[BIT_USER_HOST] = user_host_event[a];
            s[BIT_USER_ERR] = user_error_event[a];
            // Tick lands on every axis at once
            s[BIT_TICK] = tick_pulse;
         end
         assign set_vec[a*COND_W +: COND_W] = s;
      end
   endgenerate

   // ==========================================================
   // Condition memory
   logic [AXIS_W-1:0] rd_axis;
   logic reg_cond_hit;
   // Condition words sit at four consecutive locations
   assign reg_cond_hit = reg_addr >= LOC_COND_BASE &&
      reg_addr < LOC_COND_BASE + ADDR_W'(NUM_AXES);
   assign rd_axis = reg_cond_hit ?
      AXIS_W'(reg_addr - LOC_COND_BASE) : req_axis;

   // sticky bits live in shared memory
   // one axis per request
   // Reads use the word bus, so data still land one cycle after the strobe
   cond_mem u_mem (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .set_vec(set_vec),
      .clr_axis(req_axis),
      .clr_mask(req_mask),
      .clr_en(condition_clear_request),
      .rd_axis(req_axis),
      .rd_data(),
      .all_words(all_words)
   );

   // ==========================================================
   // Test request
   logic [COND_W-1:0] test_word;
   assign test_word = all_words[req_axis*COND_W +: COND_W];

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         test_valid <= 1'b0;
      end else begin
         test_valid <= condition_test_request;
      end
   end

   // masked any-set test
   // Result holds until the next test request
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         test_result <= 1'b0;
      end else if (condition_test_request) begin
         test_result <= |(test_word & req_mask);
      end
   end

   // ==========================================================
   // Periodic tick
   // Count restarts on enable, so the first tick is a full period
   assign tick_pulse = tick_en_q && tick_cnt_q ==
      TICK_CNT_W'(TICK_CYCLES - 1);

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tick_cnt_q <= '0;
      end else if (!tick_en_q || tick_pulse) begin
         tick_cnt_q <= '0;
      end else begin
         tick_cnt_q <= tick_cnt_q + 1'b1;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         periodic_tick_event <= 1'b0;
      end else begin
         periodic_tick_event <= tick_pulse;
      end
   end

   // ==========================================================
   // Shared memory locations and host interrupt
   logic [DATA_W-1:0] int_code_q;
   logic [DATA_W-1:0] offset_axis_q;
   logic [DATA_W-1:0] flag_q;
   logic [IRQ_W-1:0] irq_stat_q;
   logic [IRQ_W-1:0] irq_stat_d;
   logic [IRQ_W-1:0] irq_mask_q;
   logic [IRQ_W-1:0] irq_set;
   logic [IRQ_W-1:0] irq_clr;
   logic host_evt;
   logic off_any;
   logic [AXIS_W-1:0] off_axis;

   // Host write strobe aimed at one location
   function automatic logic wr_hit(input logic wr,
      input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] loc);
      return wr && addr == loc;
   endfunction

   // Lowest axis wins if several finish together
   always_comb begin
      off_any = 1'b0;
      off_axis = '0;
      for (int i = NUM_AXES - 1; i >= 0; i--) begin
         if (offset_done_event[i]) begin
            off_any = 1'b1;
            off_axis = AXIS_W'(i);
         end
      end
      host_evt = tick_pulse || off_any;
   end

   always_comb begin
      irq_set = '0;
      irq_set[IRQ_TICK] = tick_pulse;
      irq_set[IRQ_OFFSET] = off_any;
   end

   // Write one to clear, a new event wins
   always_comb begin
      irq_clr = '0;
      if (wr_hit(reg_wr, reg_addr, LOC_IRQ_STATUS)) begin
         irq_clr = reg_wdata[IRQ_W-1:0];
      end
      irq_stat_d = (irq_stat_q & ~irq_clr) | irq_set;
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tick_en_q <= 1'b0;
      end else if (wr_hit(reg_wr, reg_addr, LOC_TICK_EN)) begin
         tick_en_q <= reg_wdata[0];
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_mask_q <= IRQ_RESET;
      end else if (wr_hit(reg_wr, reg_addr, LOC_IRQ_MASK)) begin
         irq_mask_q <= reg_wdata[IRQ_W-1:0];
      end
   end

   // tick and offset interrupt coding
   // Offset code outranks the tick in the same cycle
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         int_code_q <= '0;
      end else if (off_any) begin
         int_code_q <= CODE_OFFSET;
      end else if (tick_pulse) begin
         int_code_q <= CODE_TICK;
      end else if (wr_hit(reg_wr, reg_addr, LOC_INT_CODE)) begin
         int_code_q <= reg_wdata;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         offset_axis_q <= '0;
      end else if (off_any) begin
         offset_axis_q <= DATA_W'(off_axis) + 1'b1;
      end
   end

   // flag bit 6 on each host interrupt
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         flag_q <= '0;
      end else if (host_evt) begin
         flag_q[FLAG_BIT_HOST_INT] <= 1'b1;
      end else if (wr_hit(reg_wr, reg_addr, LOC_FLAG)) begin
         flag_q <= reg_wdata;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_stat_q <= IRQ_RESET;
      end else begin
         irq_stat_q <= irq_stat_d;
      end
   end

   // Level follows the next status, so no extra lag
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat_d & irq_mask_q);
      end
   end

   // ==========================================================
   // Register read, data one cycle after strobe
   logic [DATA_W-1:0] rd_val;

   // Unmapped locations read as zero
   always_comb begin
      rd_val = '0;
      if (reg_cond_hit) begin
         rd_val = all_words[rd_axis*COND_W +: COND_W];
      end else begin
         case (reg_addr)
            LOC_INT_CODE: rd_val = int_code_q;
            LOC_OFFSET_AXIS: rd_val = offset_axis_q;
            LOC_FLAG: rd_val = flag_q;
            LOC_IRQ_STATUS: rd_val = DATA_W'(irq_stat_q);
            LOC_IRQ_MASK: rd_val = DATA_W'(irq_mask_q);
            LOC_TICK_EN: rd_val = DATA_W'(tick_en_q);
            default: rd_val = '0;
         endcase
      end
   end

   // Idle data read as zero between strobes
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         reg_rdata <= rd_val;
      end else begin
         reg_rdata <= '0;
      end
   end
endmodule

//--- logic/axis_irq_pkg.sv
// Package: constants for the per-axis interrupt condition bank
package axis_irq_pkg;
   localparam int NUM_AXES = 4;
   localparam int AXIS_W = 2;
   localparam int COND_W = 16;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 8;
   // Condition bit positions
   localparam int BIT_ERR_HALT = 0;
   localparam int BIT_ERR = 1;
   localparam int BIT_INDEX = 2;
   localparam int BIT_POS_BRK = 3;
   localparam int BIT_MOT_DONE = 4;
   localparam int BIT_PROBE = 5;
   localparam int BIT_CONFLICT = 6;
   localparam int BIT_IGNORED = 7;
   localparam int BIT_ENC_FAULT = 8;
   localparam int BIT_OFFSET_DONE = 10;
   localparam int BIT_USER_HOST = 12;
   localparam int BIT_USER_ERR = 13;
   localparam int BIT_TICK = 14;
   localparam logic [15:0] COND_VALID_MASK = 16'h75ff;
   localparam logic [15:0] COND_RESET = 16'h0000;
   // Shared memory locations
   localparam logic [7:0] LOC_INT_CODE = 8'h09;
   localparam logic [7:0] LOC_OFFSET_AXIS = 8'h0c;
   localparam logic [7:0] LOC_FLAG = 8'h10;
   localparam logic [7:0] LOC_IRQ_STATUS = 8'h20;
   localparam logic [7:0] LOC_IRQ_MASK = 8'h21;
   localparam logic [7:0] LOC_TICK_EN = 8'h22;
   localparam logic [7:0] LOC_COND_BASE = 8'h30;
   localparam int FLAG_BIT_HOST_INT = 6;
   localparam logic [15:0] CODE_TICK = 16'h4000;
   localparam logic [15:0] CODE_OFFSET = 16'h0400;
   // Tick timing
   localparam int CLK_HZ = 20_000_000;
   localparam int TICK_US = 5000;
   localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
   localparam int TICK_CNT_W = 17;
   // Interrupt status/mask bits
   localparam int IRQ_W = 2;
   localparam int IRQ_TICK = 0;
   localparam int IRQ_OFFSET = 1;
   localparam logic [1:0] IRQ_RESET = 2'h0;
endpackage

//--- logic/cond_mem.sv
// Small memory: per-axis condition words, registered read
`timescale 1ns/1ns
module cond_mem
   import axis_irq_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [NUM_AXES*COND_W-1:0] set_vec,
   input wire logic [AXIS_W-1:0] clr_axis,
   input wire logic [COND_W-1:0] clr_mask,
   input wire logic clr_en,
   input wire logic [AXIS_W-1:0] rd_axis,
   output logic [COND_W-1:0] rd_data,
   output logic [NUM_AXES*COND_W-1:0] all_words
);
   logic [COND_W-1:0] word_q [NUM_AXES];

   genvar g;
   generate
      for (g = 0; g < NUM_AXES; g++) begin : g_ax
         logic [COND_W-1:0] clr_m;
         assign clr_m = (clr_en && clr_axis == AXIS_W'(g)) ?
            clr_mask : '0;
         always_ff @(posedge sys_clk or posedge sys_rst) begin
            if (sys_rst) begin
               word_q[g] <= COND_RESET;
            end else begin
               word_q[g] <= ((word_q[g] & ~clr_m)
                  | set_vec[g*COND_W +: COND_W]) & COND_VALID_MASK;
            end
         end
         assign all_words[g*COND_W +: COND_W] = word_q[g];
      end
   endgenerate

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_data <= '0;
      end else begin
         rd_data <= word_q[rd_axis];
      end
   end
endmodule

//--- testbench/axis_bank_assertions.sv
// Checker: port-level properties of the condition bank
`timescale 1ns/1ns
module axis_bank_checker
   import axis_irq_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [NUM_AXES-1:0] following_error_halt_event,
   input wire logic condition_clear_request,
   input wire logic condition_test_request,
   input wire logic [AXIS_W-1:0] req_axis,
   input wire logic [COND_W-1:0] req_mask,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic test_valid,
   input wire logic test_result,
   input wire logic periodic_tick_event,
   input wire logic irq
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);
   // ==========================================
   // Properties
   test_ack_a: assert property (
      condition_test_request |=> test_valid) else $error("no test answer");
   result_hold_a: assert property (
      !condition_test_request |=> $stable(test_result))
      else $error("test result moved");
   reserved_test_a: assert property (
      condition_test_request && (req_mask & 16'h75ff) == 16'h0000
      |=> !test_result) else $error("reserved bit tested set");
   reserved_read_a: assert property (
      reg_rd && reg_addr[7:2] == 6'h0c |=> (reg_rdata & 16'h8a00) == 16'h0)
      else $error("reserved bit read set");
   rdata_idle_a: assert property (
      !reg_rd |=> reg_rdata == 16'h0000) else $error("read data not idle");
   tick_pulse_a: assert property (
      periodic_tick_event |=> !periodic_tick_event) else $error("tick long");
   event_seen_a: assert property (
      following_error_halt_event[0] ##1 !condition_clear_request ##1
      (condition_test_request && req_axis == 2'd0 && req_mask[0])
      |=> test_result) else $error("event bit lost");
   irq_mask_a: assert property (
      reg_wr && reg_addr == 8'h21 && reg_wdata[1:0] == 2'h0 |=> ##1 !irq)
      else $error("masked irq raised");
endmodule
bind axis_interrupt_status_bank axis_bank_checker chk_u (.sys_clk, .sys_rst,
   .following_error_halt_event, .condition_clear_request,
   .condition_test_request, .req_axis, .req_mask, .reg_addr, .reg_wdata,
   .reg_wr, .reg_rd, .reg_rdata, .test_valid, .test_result,
   .periodic_tick_event, .irq);

//--- testbench/host_model.sv
// Host model: register port and condition request driver
`timescale 1ns/1ns
module host_model
   import axis_irq_pkg::*;
(
   input wire logic sys_clk,
   output logic [ADDR_W-1:0] reg_addr,
   output logic [DATA_W-1:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata,
   output logic condition_clear_request,
   output logic condition_test_request,
   output logic [AXIS_W-1:0] req_axis,
   output logic [COND_W-1:0] req_mask,
   input wire logic test_valid,
   input wire logic test_result
);
   initial begin
      {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
      {condition_clear_request, condition_test_request} = 2'h0;
      {req_axis, req_mask} = '0;
   end
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   // Data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [15:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task automatic clr(input logic [1:0] n, input logic [15:0] m);
      @(posedge sys_clk);
      req_axis <= n;
      req_mask <= m;
      condition_clear_request <= 1'b1;
      @(posedge sys_clk);
      condition_clear_request <= 1'b0;
   endtask
   task automatic tst(input logic [1:0] n, input logic [15:0] m,
                      output logic [1:0] r);
      @(posedge sys_clk);
      req_axis <= n;
      req_mask <= m;
      condition_test_request <= 1'b1;
      @(posedge sys_clk);
      condition_test_request <= 1'b0;
      #1 r = {test_valid, test_result};
   endtask
endmodule

//--- testbench/testbench.sv
// Testbench: scenarios for the per-axis condition bank
`timescale 1ns/1ns
module testbench;
   import axis_irq_pkg::*;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [3:0] ev [12];
   logic [7:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, req_mask, d;
   logic reg_wr, reg_rd, clr_rq, tst_rq, test_valid, test_result, tick, irq;
   logic [1:0] req_axis, r;
   int mismatches = 0;
   int n_checks = 0;
   int cyc = 0;
   always #25 sys_clk = ~sys_clk;
   initial for (int i = 0; i < 12; i++) ev[i] = 4'h0;
   host_model host_u (.sys_clk(sys_clk), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .condition_clear_request(clr_rq),
      .condition_test_request(tst_rq), .req_axis(req_axis),
      .req_mask(req_mask), .test_valid(test_valid), .test_result(test_result));
   axis_interrupt_status_bank dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .following_error_halt_event(ev[0]), .following_error_event(ev[1]),
      .index_pulse_event(ev[2]), .position_breakpoint_event(ev[3]),
      .motion_complete_event(ev[4]), .probe_event(ev[5]),
      .conflict_event(ev[6]), .ignored_cmd_event(ev[7]),
      .encoder_fault_event(ev[8]), .offset_done_event(ev[9]),
      .user_host_event(ev[10]), .user_error_event(ev[11]),
      .condition_clear_request(clr_rq), .condition_test_request(tst_rq),
      .req_axis(req_axis), .req_mask(req_mask), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .test_valid(test_valid),
      .test_result(test_result), .periodic_tick_event(tick), .irq(irq));
   // ==========================================
   // Helpers
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic fire(input logic [11:0] s, input logic [3:0] m);
      @(posedge sys_clk);
      for (int i = 0; i < 12; i++) ev[i] <= s[i] ? m : 4'h0;
      @(posedge sys_clk);
      for (int i = 0; i < 12; i++) ev[i] <= 4'h0;
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // ==========================================
   // Scenarios
   task automatic t_events();
      logic [15:0] e;
      // Every event bit except the tick and the reserved ones
      e = 16'h35ff;
      fire(12'hfff, 4'h5);
      host_u.tst(2'd0, 16'h0001, r);
      chk({14'h0, r}, 16'h0003);
      repeat (20) @(posedge sys_clk);
      for (int a = 0; a < 4; a++) begin
         host_u.rd(LOC_COND_BASE + 8'(a), d);
         chk(d, a[0] ? 16'h0000 : e);
      end
   endtask
   task automatic t_clear();
      host_u.clr(2'd2, 16'h00f0);
      host_u.rd(8'h32, d);
      chk(d, 16'h350f);
      host_u.rd(8'h30, d);
      chk(d, 16'h35ff);
      host_u.tst(2'd2, 16'h00f0, r);
      chk({14'h0, r}, 16'h0002);
      host_u.tst(2'd2, 16'h8a00, r);
      chk({14'h0, r}, 16'h0002);
      host_u.tst(2'd2, 16'h0100, r);
      chk({14'h0, r}, 16'h0003);
   endtask
   task automatic t_race();
      fork
         host_u.clr(2'd1, 16'h0002);
         fire(12'h002, 4'h2);
      join
      host_u.rd(8'h31, d);
      chk(d, 16'h0002);
   endtask
   task automatic t_offset();
      host_u.wr(LOC_IRQ_MASK, 16'h0002);
      fire(12'h200, 4'h8);
      repeat (2) @(posedge sys_clk);
      #1 chk({15'h0, irq}, 16'h0001);
      host_u.rd(LOC_OFFSET_AXIS, d);
      chk(d, 16'h0004);
      host_u.rd(LOC_INT_CODE, d);
      chk(d, CODE_OFFSET);
      host_u.rd(LOC_FLAG, d);
      chk(d & 16'h0040, 16'h0040);
      host_u.wr(LOC_IRQ_STATUS, 16'h0002);
      host_u.rd(LOC_IRQ_STATUS, d);
      chk(d, 16'h0000);
      chk({15'h0, irq}, 16'h0000);
      host_u.wr(LOC_IRQ_MASK, 16'h0000);
      host_u.rd(8'hff, d);
      chk(d, 16'h0000);
   endtask
   // Long wait: the tick period is not shortenable
   task automatic t_tick();
      int n;
      n = 0;
      host_u.wr(LOC_FLAG, 16'h0000);
      host_u.wr(LOC_IRQ_MASK, 16'h0001);
      host_u.wr(LOC_TICK_EN, 16'h0001);
      while (tick !== 1'b1 && n < TICK_CYCLES + 10) begin
         @(posedge sys_clk);
         #1 n++;
      end
      chk(16'(n >= TICK_CYCLES - 1 && n <= TICK_CYCLES + 2), 16'h1);
      host_u.wr(LOC_TICK_EN, 16'h0000);
      chk({15'h0, irq}, 16'h0001);
      host_u.rd(LOC_COND_BASE + 8'h01, d);
      chk(d, 16'h4002);
      host_u.rd(LOC_IRQ_STATUS, d);
      chk(d, 16'h0001);
      host_u.rd(LOC_INT_CODE, d);
      chk(d, CODE_TICK);
      host_u.rd(LOC_FLAG, d);
      chk(d, 16'h0040);
   endtask
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 110000) begin
         mismatches++;
         give_verdict();
      end
   end
   initial begin
      repeat (6) @(posedge sys_clk);
      sys_rst <= 1'b0;
      host_u.rd(LOC_COND_BASE, d);
      chk(d, COND_RESET);
      t_events();
      t_clear();
      t_race();
      t_offset();
      t_tick();
      give_verdict();
   end
endmodule
